// file: logic/fetch_trap_pkg.sv
// Shared constants and types for the CPU fetch, trap and addressing front end
package fetch_trap_pkg;

   // ----------------------------------------------------------------------
   // Trap vector pair and register window
   // ----------------------------------------------------------------------
   localparam logic [15:0] TRAP_VEC_HI_ADDR = 16'hffee;
   localparam logic [15:0] TRAP_VEC_LO_ADDR = 16'hffef;
   localparam logic [15:0] REG_AREA_FIRST = 16'h0000;
   localparam logic [15:0] REG_AREA_LAST = 16'h0027;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 25000;
   // One machine cycle is forty input clocks at 40 MHz, i.e. 1000 ns
   localparam int MCYC_TIME_NS = 1000;
   localparam int MCYC_CLKS = (MCYC_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam logic [5:0] MCYC_LAST = 6'(MCYC_CLKS - 1);
   // Mask must stay clear more than this many machine cycles
   localparam logic [1:0] MASK_OPEN_CYCLES = 2'h2;

   // ----------------------------------------------------------------------
   // Stacking
   // ----------------------------------------------------------------------
   localparam logic [2:0] STACK_BYTES = 3'h7;
   localparam logic [2:0] STACK_LAST = 3'h6;
   localparam logic [15:0] STACK_DEPTH = 16'h0007;
   localparam logic [15:0] RESET_SP = 16'h0000;
   localparam logic [15:0] RESET_PC = 16'h0000;
   localparam logic [7:0] RESET_ACC = 8'h00;
   localparam logic [15:0] REL_BASE = 16'h0002;
   localparam int ACC_SEL_BIT = 4;

   // ----------------------------------------------------------------------
   // Instruction lengths
   // ----------------------------------------------------------------------
   localparam logic [1:0] LEN_ONE = 2'h1;
   localparam logic [1:0] LEN_TWO = 2'h2;
   localparam logic [1:0] LEN_THREE = 2'h3;

   typedef enum logic [2:0] {
      am_accumulator,
      am_immediate,
      am_direct,
      am_extended,
      am_indexed,
      am_implied,
      am_relative
   } addr_mode_e;

endpackage : fetch_trap_pkg

// file: logic/ea_calc.sv
// Effective address, operand and length for the seven addressing modes
`timescale 1ns/1ps
module ea_calc
   import fetch_trap_pkg::*;
(
   // Decoded instruction
   input wire addr_mode_e mode,
   input wire logic wide_imm,
   input wire logic bit_op,
   input wire logic [7:0] byte2,
   input wire logic [7:0] byte3,
   // Pointers
   input wire logic [15:0] ix,
   input wire logic [15:0] pc,
   // Results
   output logic [15:0] ea,
   output logic [15:0] operand,
   output logic [1:0] len
);

   // ----------------------------------------------------------------------
   // Adders
   // ----------------------------------------------------------------------
   wire logic [7:0] idx_off = bit_op ? byte3 : byte2;
   wire logic [8:0] idx_low = {1'b0, ix[7:0]} + {1'b0, idx_off};
   wire logic [15:0] idx_ea = {ix[15:8] + {7'h00, idx_low[8]},
      idx_low[7:0]};
   wire logic [15:0] rel_disp = {{8{byte2[7]}}, byte2};
   // Low-byte add with carry or borrow folded into the upper byte
   wire logic [15:0] rel_ea = pc + REL_BASE + rel_disp;
   wire logic [7:0] dir_off = bit_op ? byte3 : byte2;

   always_comb begin
      ea = 16'h0000;
      operand = 16'h0000;
      len = LEN_ONE;
      case (mode)
         am_accumulator: len = LEN_ONE;
         am_implied: len = LEN_ONE;
         am_immediate: begin
            if (wide_imm) begin
               operand = {byte2, byte3};
               len = LEN_THREE;
            end else begin
               operand = {8'h00, byte2};
               len = LEN_TWO;
            end
         end
         am_direct: begin
            ea = {8'h00, dir_off};
            len = bit_op ? LEN_THREE : LEN_TWO;
         end
         am_extended: begin
            ea = {byte2, byte3};
            len = LEN_THREE;
         end
         am_indexed: begin
            ea = idx_ea;
            len = bit_op ? LEN_THREE : LEN_TWO;
         end
         am_relative: begin
            ea = rel_ea;
            len = LEN_TWO;
         end
         default: len = LEN_ONE;
      endcase
   end

endmodule : ea_calc

// file: logic/fetch_trap.sv
// CPU front end: fetch traps, stacking, accumulators and address modes
`timescale 1ns/1ps
module fetch_trap
   import fetch_trap_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Opcode fetch
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   input wire logic opcode_undef,
   input wire logic [7:0] opcode,
   // Data access strobe, carried for visibility only
   input wire logic data_access,
   // Decode request
   input wire logic dec_valid,
   input wire addr_mode_e dec_mode,
   input wire logic dec_wide_imm,
   input wire logic dec_bit_op,
   input wire logic [7:0] dec_byte2,
   input wire logic [7:0] dec_byte3,
   input wire logic [15:0] dec_pc,
   // Core registers
   input wire logic [15:0] ix,
   input wire logic [15:0] sp,
   input wire logic [7:0] ccr,
   // Accumulator writes
   input wire logic acc_a_we,
   input wire logic acc_b_we,
   input wire logic acc_d_we,
   input wire logic [15:0] acc_wdata,
   // Interrupt mask control
   input wire logic clear_int_mask_op,
   input wire logic set_int_mask_op,
   input wire logic flag_transfer_op,
   input wire logic flag_transfer_mask,
   input wire logic irq_pending,
   // Memory bus
   output logic bus_req,
   output logic bus_we,
   output logic [15:0] bus_addr_ff,
   output logic [7:0] bus_wdata_ff,
   input wire logic [7:0] bus_rdata,
   // Results
   output logic mcyc_en,
   output logic trap_busy,
   output logic trap_taken,
   output logic irq_take,
   output logic pc_load_ff,
   output logic [15:0] pc_new_ff,
   output logic [15:0] sp_new_ff,
   output logic [7:0] acc_a_ff,
   output logic [7:0] acc_b_ff,
   output logic [15:0] acc_d,
   output logic acc_sel_b_ff,
   output logic [15:0] ea_ff,
   output logic [15:0] operand_ff,
   output logic [1:0] len_ff,
   output addr_mode_e mode_ff,
   output logic int_mask_ff
);

   // ----------------------------------------------------------------------
   // Machine cycle divider
   // ----------------------------------------------------------------------
   logic [5:0] div_ff;

   assign mcyc_en = (div_ff == MCYC_LAST);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_ff <= 6'h00;
      end else begin
         div_ff <= mcyc_en ? 6'h00 : div_ff + 6'h01;
      end
   end

   // ----------------------------------------------------------------------
   // Trap detection
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      st_idle,
      st_push,
      st_vec_hi,
      st_vec_lo,
      st_load
   } trap_state_e;

   trap_state_e state_ff;
   trap_state_e nxt_state;
   logic [2:0] push_cnt_ff;
   logic [15:0] ret_pc_ff;
   logic [15:0] sp_ff;
   logic [15:0] ix_ff;
   logic [7:0] ccr_ff;
   logic [7:0] vec_hi_ff;

   // Data reads and writes never reach this compare; only fetches do
   wire logic in_reg_area = (fetch_addr >= REG_AREA_FIRST) &&
      (fetch_addr <= REG_AREA_LAST);
   wire logic addr_error = fetch_valid && in_reg_area;
   wire logic op_error = fetch_valid && opcode_undef;
   wire logic idle = (state_ff == st_idle);

   // Trap wins over any maskable request raised in the same cycle
   assign trap_taken = idle && (addr_error || op_error);
   assign trap_busy = !idle;

   // ----------------------------------------------------------------------
   // Stacking sequence
   // ----------------------------------------------------------------------
   logic [7:0] push_byte [0:6];

   assign push_byte[0] = ret_pc_ff[7:0];
   assign push_byte[1] = ret_pc_ff[15:8];
   assign push_byte[2] = ix_ff[7:0];
   assign push_byte[3] = ix_ff[15:8];
   assign push_byte[4] = acc_a_ff;
   assign push_byte[5] = acc_b_ff;
   assign push_byte[6] = ccr_ff;

   wire logic [15:0] push_addr = sp_ff - {13'h0000, push_cnt_ff};
   wire logic push_done = (push_cnt_ff == STACK_LAST);

   assign bus_req = (state_ff == st_push) || (state_ff == st_vec_hi) ||
      (state_ff == st_vec_lo);
   assign bus_we = (state_ff == st_push);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         st_idle: if (trap_taken) nxt_state = st_push;
         st_push: if (mcyc_en && push_done) nxt_state = st_vec_hi;
         st_vec_hi: if (mcyc_en) nxt_state = st_vec_lo;
         st_vec_lo: if (mcyc_en) nxt_state = st_load;
         st_load: nxt_state = st_idle;
         default: nxt_state = st_idle;
      endcase
   end

   // Idle preloads the first push, so a one-clock first cycle still lands
   wire logic [15:0] nxt_bus_addr = (state_ff == st_vec_hi) ?
      TRAP_VEC_HI_ADDR : (state_ff == st_vec_lo) ? TRAP_VEC_LO_ADDR :
      idle ? sp : push_addr;
   wire logic [7:0] nxt_bus_wdata = idle ? fetch_addr[7:0] :
      push_byte[push_cnt_ff];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= st_idle;
         push_cnt_ff <= 3'h0;
      end else begin
         state_ff <= nxt_state;
         if (state_ff != st_push) begin
            push_cnt_ff <= 3'h0;
         end else if (mcyc_en && !push_done) begin
            push_cnt_ff <= push_cnt_ff + 3'h1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ret_pc_ff <= RESET_PC;
         sp_ff <= RESET_SP;
         ix_ff <= RESET_PC;
         ccr_ff <= 8'h00;
      end else if (trap_taken) begin
         ret_pc_ff <= fetch_addr;
         sp_ff <= sp;
         ix_ff <= ix;
         ccr_ff <= ccr;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bus_addr_ff <= 16'h0000;
         bus_wdata_ff <= 8'h00;
      end else begin
         bus_addr_ff <= nxt_bus_addr;
         bus_wdata_ff <= nxt_bus_wdata;
      end
   end

   // ----------------------------------------------------------------------
   // Vector load
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vec_hi_ff <= 8'h00;
         pc_load_ff <= 1'b0;
         pc_new_ff <= RESET_PC;
         sp_new_ff <= RESET_SP;
      end else begin
         pc_load_ff <= (state_ff == st_load);
         if (state_ff == st_vec_hi && mcyc_en) begin
            vec_hi_ff <= bus_rdata;
         end
         if (state_ff == st_vec_lo && mcyc_en) begin
            pc_new_ff <= {vec_hi_ff, bus_rdata};
            sp_new_ff <= sp_ff - STACK_DEPTH;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Accumulators
   // ----------------------------------------------------------------------
   assign acc_d = {acc_a_ff, acc_b_ff};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_a_ff <= RESET_ACC;
         acc_b_ff <= RESET_ACC;
      end else if (acc_d_we) begin
         acc_a_ff <= acc_wdata[15:8];
         acc_b_ff <= acc_wdata[7:0];
      end else begin
         if (acc_a_we) acc_a_ff <= acc_wdata[7:0];
         if (acc_b_we) acc_b_ff <= acc_wdata[7:0];
      end
   end

   // ----------------------------------------------------------------------
   // Effective address
   // ----------------------------------------------------------------------
   logic [15:0] ea_comb;
   logic [15:0] operand_comb;
   logic [1:0] len_comb;

   ea_calc u_ea_calc (
      .mode(dec_mode),
      .wide_imm(dec_wide_imm),
      .bit_op(dec_bit_op),
      .byte2(dec_byte2),
      .byte3(dec_byte3),
      .ix(ix),
      .pc(dec_pc),
      .ea(ea_comb),
      .operand(operand_comb),
      .len(len_comb)
   );

   // Index stays an input; the sum lives only here
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ea_ff <= 16'h0000;
         operand_ff <= 16'h0000;
         len_ff <= LEN_ONE;
         mode_ff <= am_implied;
         acc_sel_b_ff <= 1'b0;
      end else if (dec_valid) begin
         ea_ff <= ea_comb;
         operand_ff <= operand_comb;
         len_ff <= len_comb;
         mode_ff <= dec_mode;
         acc_sel_b_ff <= opcode[ACC_SEL_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // Interrupt mask window
   // ----------------------------------------------------------------------
   // A clear followed too soon by a set leaves the request waiting
   logic [1:0] open_cnt_ff;
   wire logic nxt_mask = set_int_mask_op ? 1'b1 :
      clear_int_mask_op ? 1'b0 :
      flag_transfer_op ? flag_transfer_mask : int_mask_ff;
   wire logic window_open = !int_mask_ff &&
      (open_cnt_ff > MASK_OPEN_CYCLES);

   assign irq_take = irq_pending && window_open && idle &&
      !trap_taken;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         int_mask_ff <= 1'b1;
         open_cnt_ff <= 2'h0;
      end else begin
         int_mask_ff <= nxt_mask;
         if (nxt_mask) begin
            open_cnt_ff <= 2'h0;
         // Only cycle ends reached with the mask already clear may count
         end else if (mcyc_en && !int_mask_ff && open_cnt_ff != 2'h3) begin
            open_cnt_ff <= open_cnt_ff + 2'h1;
         end
      end
   end

   wire logic unused_ok = data_access;

endmodule : fetch_trap

// file: bench/prog_mem_model.sv
// Program memory model on the far side of the fetch and trap bus
`timescale 1ns/1ps
module prog_mem_model #(
   parameter logic [7:0] VEC_HI = 8'h9a,
   parameter logic [7:0] VEC_LO = 8'h3c
) (
   // Clock and machine cycle
   input wire logic clk,
   input wire logic mcyc_en,
   // Bus
   input wire logic bus_req,
   input wire logic bus_we,
   input wire logic [15:0] bus_addr_ff,
   input wire logic [7:0] bus_wdata_ff,
   output logic [7:0] bus_rdata
);
   logic [7:0] mem [0:65535];
   logic [7:0] last_ff = 8'h00;
   wire rd_now = bus_req & ~bus_we;

   initial begin
      mem[16'hffee] = VEC_HI;
      mem[16'hffef] = VEC_LO;
   end

   // Released bus toggles each cycle so a stale byte can never pass
   assign bus_rdata = rd_now ? mem[bus_addr_ff] : ~last_ff;

   always @(posedge clk) begin
      if (mcyc_en && bus_req && bus_we) begin
         mem[bus_addr_ff] <= bus_wdata_ff;
      end
      last_ff <= bus_rdata;
   end
endmodule : prog_mem_model

// file: bench/fetch_trap_checker.sv
// Concurrent checks on the ports of the fetch and trap front end
`timescale 1ns/1ps
module fetch_trap_checker
   import fetch_trap_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Inputs watched
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   input wire logic opcode_undef,
   input wire logic dec_valid,
   input wire addr_mode_e dec_mode,
   input wire logic dec_bit_op,
   input wire logic [7:0] dec_byte2,
   input wire logic [7:0] dec_byte3,
   input wire logic [15:0] dec_pc,
   input wire logic [15:0] sp,
   input wire logic acc_d_we,
   input wire logic [15:0] acc_wdata,
   input wire logic irq_pending,
   // Outputs watched
   input wire logic trap_busy,
   input wire logic trap_taken,
   input wire logic irq_take,
   input wire logic pc_load_ff,
   input wire logic [15:0] sp_new_ff,
   input wire logic [15:0] acc_d,
   input wire logic [15:0] ea_ff,
   input wire logic [1:0] len_ff,
   input wire logic int_mask_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   logic [7:0] clr_cnt_ff;
   wire [15:0] rel_ea = dec_pc + 16'h0002 + {{8{dec_byte2[7]}}, dec_byte2};

   // Clocks the mask has stayed clear, saturating
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clr_cnt_ff <= 8'h00;
      end else if (int_mask_ff) begin
         clr_cnt_ff <= 8'h00;
      end else if (clr_cnt_ff != 8'hff) begin
         clr_cnt_ff <= clr_cnt_ff + 8'h01;
      end
   end

   a_trap_on_fault: assert property (
      fetch_valid && !trap_busy && (opcode_undef ||
      fetch_addr <= REG_AREA_LAST) |-> trap_taken)
      else $error("fault fetch did not trap");
   a_no_false_trap: assert property (
      trap_taken |-> fetch_valid && (opcode_undef ||
      fetch_addr <= REG_AREA_LAST))
      else $error("trap without faulting fetch");
   a_busy_next: assert property (trap_taken |=> trap_busy)
      else $error("busy missing after trap");
   a_irq_blocked: assert property (
      trap_taken || trap_busy |-> !irq_take)
      else $error("interrupt taken over trap");
   a_vector_load: assert property (
      trap_taken |-> ##[300:420] pc_load_ff)
      else $error("vector load late or missing");
   a_sp_rewind: assert property (
      pc_load_ff |-> sp_new_ff == sp - 16'h0007)
      else $error("stack pointer after trap wrong");
   a_double_acc: assert property (
      acc_d_we |=> acc_d == $past(acc_wdata))
      else $error("double accumulator write wrong");
   a_ext_addr: assert property (
      dec_valid && dec_mode == am_extended |=>
      ea_ff == {$past(dec_byte2), $past(dec_byte3)} && len_ff == 2'h3)
      else $error("extended address wrong");
   a_rel_target: assert property (
      dec_valid && dec_mode == am_relative |=> ea_ff == $past(rel_ea))
      else $error("branch target wrong");
   a_direct_page: assert property (
      dec_valid && dec_mode == am_direct && !dec_bit_op |=>
      ea_ff == {8'h00, $past(dec_byte2)} && len_ff == 2'h2)
      else $error("direct address wrong");
   a_mask_window: assert property (
      irq_take |-> irq_pending && !int_mask_ff && clr_cnt_ff >= 8'h51)
      else $error("interrupt taken in short window");
endmodule : fetch_trap_checker

bind fetch_trap fetch_trap_checker fetch_trap_checker_inst (.clk, .rst,
   .fetch_valid, .fetch_addr, .opcode_undef, .dec_valid, .dec_mode,
   .dec_bit_op, .dec_byte2, .dec_byte3, .dec_pc, .sp, .acc_d_we,
   .acc_wdata, .irq_pending, .trap_busy, .trap_taken, .irq_take,
   .pc_load_ff, .sp_new_ff, .acc_d, .ea_ff, .len_ff, .int_mask_ff);

// file: bench/tb_top.sv
// Self-checking bench for the fetch, trap and addressing front end
`timescale 1ns/1ps
module tb_top;
   import fetch_trap_pkg::*;
   localparam logic [7:0] VEC_HI = 8'h9a;
   localparam logic [7:0] VEC_LO = 8'h3c;
   localparam int LIMIT = 10000;

   typedef struct packed {
      addr_mode_e m;
      logic w, b;
      logic [7:0] b2, b3;
      logic [15:0] base, exp;
      logic [1:0] len, chk;
   } row_s;

   logic clk = 1'h0;
   logic rst = 1'h1;
   logic fetch_valid = 1'h0, opcode_undef = 1'h0, data_access = 1'h0;
   logic dec_valid = 1'h0, dec_wide_imm = 1'h0, dec_bit_op = 1'h0;
   logic acc_a_we = 1'h0, acc_b_we = 1'h0, acc_d_we = 1'h0;
   logic irq_pending = 1'h1, clear_int_mask_op = 1'h0;
   logic set_int_mask_op = 1'h0, flag_transfer_op = 1'h0;
   logic flag_transfer_mask = 1'h1, seen_irq = 1'h0;
   logic [7:0] opcode = 8'h00, dec_byte2 = 8'h00, dec_byte3 = 8'h00;
   logic [7:0] ccr = 8'hc5;
   logic [15:0] fetch_addr = 16'h1000, dec_pc = 16'h0000, ix = 16'h0000;
   logic [15:0] sp = 16'h01ff, acc_wdata = 16'h0000;
   addr_mode_e dec_mode = am_implied;
   logic bus_req, bus_we, mcyc_en, trap_busy, trap_taken, irq_take;
   logic pc_load_ff, acc_sel_b_ff, int_mask_ff;
   logic [7:0] bus_rdata, bus_wdata_ff, acc_a_ff, acc_b_ff;
   logic [15:0] bus_addr_ff, pc_new_ff, sp_new_ff, acc_d, ea_ff, operand_ff;
   logic [1:0] len_ff;
   addr_mode_e mode_ff;
   int failures = 0, n_tests = 0, cycles = 0;

   // chk: 1 compares ea_ff, 2 compares operand_ff
   row_s rows [12] = '{
      '{am_accumulator,1'h0,1'h0,8'h4f,8'h00,16'h0,16'h0,2'h1,2'h0},
      '{am_accumulator,1'h0,1'h0,8'h5f,8'h00,16'h0,16'h0,2'h1,2'h0},
      '{am_immediate,1'h0,1'h0,8'h3c,8'h00,16'h0,16'h003c,2'h2,2'h2},
      '{am_immediate,1'h1,1'h0,8'h12,8'h34,16'h0,16'h1234,2'h3,2'h2},
      '{am_direct,1'h0,1'h0,8'h80,8'h00,16'h0,16'h0080,2'h2,2'h1},
      '{am_direct,1'h0,1'h1,8'hff,8'h27,16'h0,16'h0027,2'h3,2'h1},
      '{am_extended,1'h0,1'h0,8'h12,8'h34,16'h0,16'h1234,2'h3,2'h1},
      '{am_indexed,1'h0,1'h0,8'h20,8'h00,16'h12f0,16'h1310,2'h2,2'h1},
      '{am_indexed,1'h0,1'h1,8'h55,8'h01,16'h00ff,16'h0100,2'h3,2'h1},
      '{am_implied,1'h0,1'h0,8'h00,8'h00,16'h0,16'h0,2'h1,2'h0},
      '{am_relative,1'h0,1'h0,8'h7f,8'h00,16'h10f0,16'h1171,2'h2,2'h1},
      '{am_relative,1'h0,1'h0,8'h80,8'h00,16'h1000,16'h0f82,2'h2,2'h1}
   };

   fetch_trap fetch_trap_inst (.clk, .rst, .fetch_valid, .fetch_addr,
      .opcode_undef, .opcode, .data_access, .dec_valid, .dec_mode,
      .dec_wide_imm, .dec_bit_op, .dec_byte2, .dec_byte3, .dec_pc, .ix,
      .sp, .ccr, .acc_a_we, .acc_b_we, .acc_d_we, .acc_wdata,
      .clear_int_mask_op, .set_int_mask_op, .flag_transfer_op,
      .flag_transfer_mask, .irq_pending, .bus_req, .bus_we, .bus_addr_ff,
      .bus_wdata_ff, .bus_rdata, .mcyc_en, .trap_busy, .trap_taken,
      .irq_take, .pc_load_ff, .pc_new_ff, .sp_new_ff, .acc_a_ff,
      .acc_b_ff, .acc_d, .acc_sel_b_ff, .ea_ff, .operand_ff, .len_ff,
      .mode_ff, .int_mask_ff);

   prog_mem_model #(.VEC_HI(VEC_HI), .VEC_LO(VEC_LO)) prog_mem_model_inst (
      .clk, .mcyc_en, .bus_req, .bus_we, .bus_addr_ff, .bus_wdata_ff,
      .bus_rdata);

   // ---------------------------------------------------------------
   // Clock, watchdog and reporting
   // ---------------------------------------------------------------
   always #12.5 clk = ~clk;

   // Sampled on the falling edge, where the outputs have settled
   always @(negedge clk) begin
      cycles++;
      if (irq_take === 1'h1) begin
         seen_irq <= 1'h1;
      end
      if (cycles == LIMIT) begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      if (failures == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // Fetch aligned just after a machine cycle edge, then follow the trap
   task automatic run_fetch(input logic [15:0] a, input logic undef,
                            input logic trap);
      int i;
      logic [7:0] stk [7];
      logic [7:0] got;
      @(negedge clk iff mcyc_en);
      // Snapshot once the core registers set before the call have landed
      stk = '{a[7:0], a[15:8], ix[7:0], ix[15:8], 8'hbe, 8'hef, ccr};
      @(posedge clk);
      fetch_valid <= 1'h1;
      fetch_addr <= a;
      opcode_undef <= undef;
      @(negedge clk);
      check(16'(trap_taken), 16'(trap));
      // The open window takes the pending request unless a trap competes
      check(16'(irq_take), 16'(!trap));
      @(posedge clk);
      fetch_valid <= 1'h0;
      opcode_undef <= 1'h0;
      i = 0;
      while (trap && pc_load_ff !== 1'h1 && i < 600) begin
         @(negedge clk);
         i++;
      end
      if (!trap) begin
         @(negedge clk);
         check(16'(trap_busy), 16'h0000);
         return;
      end
      check(pc_new_ff, {VEC_HI, VEC_LO});
      for (i = 0; i < 7; i++) begin
         got = prog_mem_model_inst.mem[sp - 16'(i)];
         check(16'(got), 16'(stk[i]));
      end
   endtask : run_fetch

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      // Mask reopened for only two machine cycles
      @(posedge clk);
      clear_int_mask_op <= 1'h1;
      @(posedge clk);
      clear_int_mask_op <= 1'h0;
      repeat (2) @(negedge clk iff mcyc_en);
      @(posedge clk);
      set_int_mask_op <= 1'h1;
      @(posedge clk);
      set_int_mask_op <= 1'h0;
      @(negedge clk);
      check(16'(seen_irq), 16'h0000);
      // Flag transfer clears the mask; the window opens after three machine cycles
      @(posedge clk);
      flag_transfer_op <= 1'h1;
      flag_transfer_mask <= 1'h0;
      @(posedge clk);
      flag_transfer_op <= 1'h0;
      repeat (3) @(negedge clk iff mcyc_en);
      repeat (2) @(negedge clk);
      check(16'(irq_take), 16'h0001);
      // Double accumulator replaces both halves
      @(posedge clk);
      acc_a_we <= 1'h1;
      acc_wdata <= 16'h0011;
      @(posedge clk);
      acc_a_we <= 1'h0;
      acc_d_we <= 1'h1;
      acc_wdata <= 16'hbeef;
      @(posedge clk);
      acc_d_we <= 1'h0;
      @(negedge clk);
      check({acc_a_ff, acc_b_ff}, 16'hbeef);
      foreach (rows[i]) begin
         @(posedge clk);
         dec_valid <= 1'h1;
         dec_mode <= rows[i].m;
         dec_wide_imm <= rows[i].w;
         dec_bit_op <= rows[i].b;
         dec_byte2 <= rows[i].b2;
         dec_byte3 <= rows[i].b3;
         opcode <= rows[i].b2;
         dec_pc <= rows[i].base;
         ix <= rows[i].base;
         @(posedge clk);
         dec_valid <= 1'h0;
         @(negedge clk);
         check(16'(len_ff), 16'(rows[i].len));
         check(16'(mode_ff), 16'(rows[i].m));
         if (rows[i].chk == 2'h1) begin
            check(ea_ff, rows[i].exp);
         end
         if (rows[i].chk == 2'h2) begin
            check(operand_ff, rows[i].exp);
         end
         if (rows[i].m == am_accumulator) begin
            check(16'(acc_sel_b_ff), 16'(rows[i].b2[4]));
         end
      end
      // Faulting and clean fetches with an unmasked interrupt pending throughout
      @(posedge clk);
      ix <= 16'ha1b2;
      run_fetch(16'h4321, 1'h1, 1'h1);
      run_fetch(16'h0000, 1'h0, 1'h1);
      run_fetch(16'h0027, 1'h0, 1'h1);
      run_fetch(16'h0028, 1'h0, 1'h0);
      @(posedge clk);
      data_access <= 1'h1;
      fetch_addr <= 16'h0010;
      @(negedge clk);
      check(16'(trap_taken), 16'h0000);
      // Reset in mid-run restores the documented state
      @(posedge clk);
      data_access <= 1'h0;
      rst <= 1'h1;
      @(negedge clk);
      check(16'(int_mask_ff), 16'h0001);
      check(16'(len_ff), 16'(LEN_ONE));
      check(16'(trap_busy), 16'h0000);
      check(acc_d, {RESET_ACC, RESET_ACC});
      @(posedge clk);
      rst <= 1'h0;
      tally_and_finish();
   end
endmodule : tb_top
